//--- logic/serial_host_port_pkg.sv
// Shared constants for the serial host register port.
package serial_host_port_pkg;
  localparam int          CLK_HZ          = 50000000;
  localparam int          RESET_MIN_NS    = 40;
  localparam int          RESET_MIN_CYC   = (RESET_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [6:0]  I2C_ADDR_BASE   = 7'h30;
  localparam int          CTRL_RW_BIT     = 7;
  localparam int          CTRL_REG_HI     = 6;
  localparam int          CTRL_REG_LO     = 3;
  localparam int          CTRL_CH_HI      = 2;
  localparam int          CTRL_CH_LO      = 1;
  localparam logic [1:0]  CH_FIRST        = 2'h0;
  localparam logic [1:0]  CH_SECOND       = 2'h1;
  localparam int          FIFO_DEPTH      = 64;
  localparam int          LEVEL_W         = 7;
  localparam logic [3:0]  REG_HOLDING     = 4'h0;
  localparam logic [3:0]  REG_FIFO_CTRL   = 4'h2;
  localparam logic [7:0]  FIFO_CTRL_RESET = 8'h00;
  localparam int          FIFO_EN_BIT     = 0;
endpackage : serial_host_port_pkg

//--- logic/edge_sync.sv
// Three-stage synchroniser with agreement-based change detection and edge pulses.
`timescale 1ns/10ps
module edge_sync (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic din,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic [2:0] stage_reg;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stage_reg <= 3'h7;
    end else begin
      stage_reg <= {stage_reg[1:0], din};
    end
  end

  // The filtered level only changes once the second and third stages agree.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      level <= 1'b1;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else begin
      rise <= 1'b0;
      fall <= 1'b0;
      if (stage_reg[1] == stage_reg[2] && stage_reg[2] != level) begin
        level <= stage_reg[2];
        rise  <= stage_reg[2];
        fall  <= ~stage_reg[2];
      end
    end
  end
endmodule // edge_sync

//--- logic/serial_host_register_port.sv
// Serial host register port: I2C or SPI target decoding control bytes into register accesses.
`timescale 1ns/10ps
module serial_host_register_port
  import serial_host_port_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  input  wire logic                 ifaceSelI2c,
  input  wire logic [1:0]           addr_strap_hi,
  input  wire logic [1:0]           addr_strap_lo,
  input  wire logic                 sclIn,
  input  wire logic                 sdaIn,
  output logic                      sdaOut,
  output logic                      sdaOe_n,
  input  wire logic                 chipSel_n,
  input  wire logic                 slaveIn,
  output logic                      slaveOut,
  output logic                      regWrite,
  output logic                      regRead,
  output logic [0:0]                regChan,
  output logic [3:0]                regAddr,
  output logic [7:0]                regWdata,
  input  wire logic [7:0]           regRdata,
  input  wire logic [1:0]           txFull,
  input  wire logic                 rs485Auto,
  input  wire logic                 txHoldEmpty,
  input  wire logic                 txAllEmpty,
  input  wire logic [LEVEL_W-1:0]   txLevel,
  input  wire logic [LEVEL_W-1:0]   txTrigger,
  input  wire logic [LEVEL_W-1:0]   rxLevel,
  input  wire logic [LEVEL_W-1:0]   rxTrigger,
  input  wire logic                 rxDataReady,
  output logic                      irq_n,
  output logic                      fifoEnable
);
  import serial_host_port_pkg::*;

  typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK, ST_WDATA, ST_WACK,
                ST_RDATA, ST_RACK, ST_IGNORE} i2c_state_e;

  // Strap code: 0 supply, 1 ground, 2 clock, 3 data; the high pin reads supply and clock alike.
  function automatic logic [2:0] strapBits(input logic [1:0] hiCode, input logic [1:0] loCode);
    strapBits = {hiCode[0], loCode};
  endfunction

  function automatic logic chanOk(input logic [7:0] ctrl);
    chanOk = (ctrl[CTRL_CH_HI:CTRL_CH_LO] == CH_FIRST) || (ctrl[CTRL_CH_HI:CTRL_CH_LO] == CH_SECOND);
  endfunction

  // All host-side logic runs from clk_sys with bus pins sampled; no crystal clock here.
  logic sclLvl, sclRise, sclFall;
  logic sdaLvl, sdaRise, sdaFall;
  logic csLvl, csRise, csFall;
  logic siLvl;

  edge_sync u_scl (.clk_sys(clk_sys), .rstn(rstn), .din(sclIn), .level(sclLvl), .rise(sclRise), .fall(sclFall));
  edge_sync u_sda (.clk_sys(clk_sys), .rstn(rstn), .din(sdaIn), .level(sdaLvl), .rise(sdaRise), .fall(sdaFall));
  edge_sync u_cs  (.clk_sys(clk_sys), .rstn(rstn), .din(chipSel_n), .level(csLvl), .rise(csRise), .fall(csFall));
  edge_sync u_si  (.clk_sys(clk_sys), .rstn(rstn), .din(slaveIn), .level(siLvl), .rise(), .fall());

  // Mode is captured in a clocked process after reset release, not by the reset itself.
  logic modeI2c_reg;
  logic [6:0] myAddr_reg;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      modeI2c_reg <= 1'b0;
      myAddr_reg  <= 7'h00;
    end else begin
      modeI2c_reg <= ifaceSelI2c;
      myAddr_reg  <= I2C_ADDR_BASE | {4'h0, strapBits(addr_strap_hi, addr_strap_lo)};
    end
  end

  logic i2cStart, i2cStop;
  assign i2cStart = modeI2c_reg && sdaFall && sclLvl;
  assign i2cStop  = modeI2c_reg && sdaRise && sclLvl;

  // ---------------- SPI engine ----------------
  logic [2:0] spiBit_reg;
  logic [7:0] spiShift_reg;
  logic [7:0] spiCtrl_reg;
  logic       spiHaveCtrl_reg;
  logic [7:0] spiOut_reg;
  logic [6:0] spiCount_reg;
  logic       spiActive;
  assign spiActive = !modeI2c_reg && !csLvl;

  logic spiByteDone;
  assign spiByteDone = spiActive && sclRise && spiBit_reg == 3'h7;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      spiBit_reg      <= 3'h0;
      spiShift_reg    <= 8'h00;
      spiCtrl_reg     <= 8'h00;
      spiHaveCtrl_reg <= 1'b0;
      spiCount_reg    <= 7'h00;
    end else if (!spiActive) begin
      spiBit_reg      <= 3'h0;
      spiHaveCtrl_reg <= 1'b0;
      spiCount_reg    <= 7'h00;
    end else if (sclRise) begin
      spiShift_reg <= {spiShift_reg[6:0], siLvl};
      spiBit_reg   <= spiBit_reg + 3'h1;
      if (spiBit_reg == 3'h7) begin
        if (!spiHaveCtrl_reg) begin
          spiCtrl_reg     <= {spiShift_reg[6:0], siLvl};
          spiHaveCtrl_reg <= 1'b1;
        end else if (spiCount_reg < 7'(FIFO_DEPTH)) begin
          spiCount_reg <= spiCount_reg + 7'h1;
        end
      end
    end
  end

  // ---------------- I2C engine ----------------
  i2c_state_e i2cState_reg;
  logic [2:0] i2cBit_reg;
  logic [7:0] i2cShift_reg;
  logic       i2cRead_reg;
  logic [7:0] i2cSub_reg;
  logic [7:0] i2cOut_reg;
  logic       i2cNack_reg;
  logic       i2cBitSeen_reg;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      i2cState_reg <= ST_IDLE;
      i2cBit_reg   <= 3'h0;
      i2cShift_reg <= 8'h00;
      i2cRead_reg  <= 1'b0;
      i2cSub_reg   <= 8'h00;
      i2cNack_reg  <= 1'b0;
      i2cBitSeen_reg <= 1'b0;
    end else if (i2cStop || !modeI2c_reg) begin
      i2cState_reg <= ST_IDLE;
    end else if (i2cStart) begin
      i2cState_reg <= ST_ADDR;
      i2cBit_reg   <= 3'h0;
      i2cBitSeen_reg <= 1'b0;
    end else if (sclRise) begin
      case (i2cState_reg)
        ST_ADDR, ST_SUB, ST_WDATA: begin
          i2cShift_reg <= {i2cShift_reg[6:0], sdaLvl};
          i2cBit_reg   <= i2cBit_reg + 3'h1;
          i2cBitSeen_reg <= 1'b1;
        end
        ST_RACK: begin
          i2cState_reg <= sdaLvl ? ST_IGNORE : ST_RACK;
        end
        default: begin
          i2cState_reg <= i2cState_reg;
        end
      endcase
    end else if (sclFall) begin
      case (i2cState_reg)
        ST_ADDR: begin
          // The clock fall that ends a start condition comes before any bit was shifted.
          if (i2cBit_reg == 3'h0 && i2cBitSeen_reg) begin
            if (i2cShift_reg[7:1] == myAddr_reg) begin
              i2cRead_reg  <= i2cShift_reg[0];
              i2cState_reg <= ST_ADDR_ACK;
            end else begin
              i2cState_reg <= ST_IGNORE;
            end
          end
        end
        ST_ADDR_ACK: begin
          i2cState_reg <= i2cRead_reg ? ST_RDATA : ST_SUB;
        end
        ST_SUB: begin
          if (i2cBit_reg == 3'h0) begin
            i2cSub_reg   <= i2cShift_reg;
            i2cState_reg <= ST_SUB_ACK;
          end
        end
        ST_SUB_ACK: begin
          i2cState_reg <= ST_WDATA;
        end
        ST_WDATA: begin
          if (i2cBit_reg == 3'h0) begin
            i2cNack_reg  <= i2cSub_reg[CTRL_REG_HI:CTRL_REG_LO] == REG_HOLDING
                            && txFull[i2cSub_reg[CTRL_CH_LO]];
            i2cState_reg <= ST_WACK;
          end
        end
        ST_WACK: begin
          i2cState_reg <= ST_WDATA;
        end
        ST_RACK: begin
          i2cState_reg <= ST_RDATA;
        end
        ST_RDATA: begin
          if (i2cBit_reg == 3'h7) begin
            i2cState_reg <= ST_RACK;
          end
          i2cBit_reg <= i2cBit_reg + 3'h1;
        end
        default: begin
          i2cState_reg <= i2cState_reg;
        end
      endcase
    end
  end

  // ---------------- Register access strobes ----------------
  logic [7:0] ctrlByte;
  logic       isRead;
  assign ctrlByte = modeI2c_reg ? i2cSub_reg : spiCtrl_reg;
  assign isRead   = modeI2c_reg ? i2cRead_reg : spiCtrl_reg[CTRL_RW_BIT];

  logic wrPulse, rdPulse;
  assign wrPulse = (modeI2c_reg && sclFall && i2cState_reg == ST_WDATA && i2cBit_reg == 3'h0 && !i2cStart)
                 || (spiByteDone && spiHaveCtrl_reg && !spiCtrl_reg[CTRL_RW_BIT]
                     && spiCount_reg < 7'(FIFO_DEPTH));
  logic [7:0] spiCtrlNow;
  assign spiCtrlNow = spiHaveCtrl_reg ? spiCtrl_reg : {spiShift_reg[6:0], siLvl};

  // Fetch the next byte one byte period ahead; a frame cut short leaves one byte fetched but unsent.
  assign rdPulse = (modeI2c_reg && sclFall && (i2cState_reg == ST_ADDR_ACK && i2cRead_reg))
                 || (modeI2c_reg && sclRise && i2cState_reg == ST_RACK && !sdaLvl)
                 || (spiByteDone && spiCtrlNow[CTRL_RW_BIT] && spiCount_reg < 7'(FIFO_DEPTH - 1));

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      regWrite <= 1'b0;
      regRead  <= 1'b0;
      regChan  <= 1'b0;
      regAddr  <= 4'h0;
      regWdata <= 8'h00;
    end else begin
      regWrite <= 1'b0;
      regRead  <= 1'b0;
      if (wrPulse && chanOk(ctrlByte) && !(modeI2c_reg && isRead)) begin
        regWrite <= 1'b1;
        regChan  <= ctrlByte[CTRL_CH_LO];
        regAddr  <= ctrlByte[CTRL_REG_HI:CTRL_REG_LO];
        regWdata <= modeI2c_reg ? i2cShift_reg : {spiShift_reg[6:0], siLvl};
      end
      if (rdPulse && chanOk(modeI2c_reg ? ctrlByte : spiCtrlNow)) begin
        regRead <= 1'b1;
        regChan <= modeI2c_reg ? ctrlByte[CTRL_CH_LO] : spiCtrlNow[CTRL_CH_LO];
        regAddr <= modeI2c_reg ? ctrlByte[CTRL_REG_HI:CTRL_REG_LO] : spiCtrlNow[CTRL_REG_HI:CTRL_REG_LO];
      end
    end
  end

  // Read data lands one cycle after the strobe; it is latched into the shifters then.
  logic readLoad_reg;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      readLoad_reg <= 1'b0;
    end else begin
      readLoad_reg <= regRead;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      spiOut_reg <= 8'h00;
      i2cOut_reg <= 8'h00;
    end else begin
      if (readLoad_reg) begin
        spiOut_reg <= regRdata;
        i2cOut_reg <= regRdata;
      end else if (spiActive && sclFall && spiHaveCtrl_reg) begin
        spiOut_reg <= {spiOut_reg[6:0], 1'b0};
      end else if (modeI2c_reg && sclFall && i2cState_reg == ST_RDATA) begin
        i2cOut_reg <= {i2cOut_reg[6:0], 1'b0};
      end
    end
  end

  // Pin drivers: open-drain SDA pulls low only; enable low means driving.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sdaOut   <= 1'b1;
      sdaOe_n  <= 1'b1;
      slaveOut <= 1'b0;
    end else begin
      slaveOut <= spiActive ? spiOut_reg[7] : 1'b0;
      sdaOut   <= 1'b0;
      case (i2cState_reg)
        ST_ADDR_ACK, ST_SUB_ACK: sdaOe_n <= 1'b0;
        ST_WACK:                 sdaOe_n <= i2cNack_reg;
        ST_RDATA:                sdaOe_n <= i2cOut_reg[7];
        default:                 sdaOe_n <= 1'b1;
      endcase
    end
  end

  // FIFO enable mirror: clears at reset, follows writes to the FIFO control register.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fifoEnable <= FIFO_CTRL_RESET[FIFO_EN_BIT];
    end else if (wrPulse && chanOk(ctrlByte) && ctrlByte[CTRL_REG_HI:CTRL_REG_LO] == REG_FIFO_CTRL
                 && !(modeI2c_reg && isRead)) begin
      fifoEnable <= modeI2c_reg ? i2cShift_reg[FIFO_EN_BIT] : siLvl;
    end
  end

  // Interrupt pin, active low, combining transmitter and receiver requests.
  logic txReq, rxReq;
  always_comb begin
    if (fifoEnable) begin
      txReq = (txLevel < txTrigger) || (rs485Auto ? txAllEmpty : (txLevel == '0));
      rxReq = rxLevel > rxTrigger;
    end else begin
      txReq = rs485Auto ? txAllEmpty : txHoldEmpty;
      rxReq = rxDataReady;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~(txReq | rxReq);
    end
  end
endmodule // serial_host_register_port

//--- bench/spi_host_model.sv
// Behavioural SPI host that frames and shifts bytes for the register port.
`timescale 1ns/10ps
module spi_host_model #(
  parameter int HALF_NS = 80
) (
  output logic      sck,
  output logic      csN,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
  end
  // The odd offset keeps the link edges away from the system clock edges.
  task automatic start();
    #7;
    csN = 1'b0;
    #(HALF_NS);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #(HALF_NS);
      sck = 1'b1;
      rx[i] = miso;
      #(HALF_NS);
      sck = 1'b0;
    end
  endtask
  // A released data line shows the inverse of its last bit, since nothing holds it.
  task automatic stop();
    #(HALF_NS);
    csN = 1'b1;
    mosi = ~mosi;
  endtask
endmodule // spi_host_model

//--- bench/serial_host_port_chk.sv
// Port-level checker for the serial host register port.
`timescale 1ns/10ps
module serial_host_port_chk
  import serial_host_port_pkg::*;
(
  input wire logic               clk_sys,
  input wire logic               rstn,
  input wire logic               ifaceSelI2c,
  input wire logic               chipSel_n,
  input wire logic               sdaOe_n,
  input wire logic               regWrite,
  input wire logic               regRead,
  input wire logic [3:0]         regAddr,
  input wire logic [7:0]         regWdata,
  input wire logic               rs485Auto,
  input wire logic               txHoldEmpty,
  input wire logic               txAllEmpty,
  input wire logic [LEVEL_W-1:0] txLevel,
  input wire logic [LEVEL_W-1:0] txTrigger,
  input wire logic [LEVEL_W-1:0] rxLevel,
  input wire logic [LEVEL_W-1:0] rxTrigger,
  input wire logic               rxDataReady,
  input wire logic               irq_n,
  input wire logic               fifoEnable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic [3:0] csIdle_reg;
  logic       fifoWr;
  assign fifoWr = regWrite && (regAddr == REG_FIFO_CTRL);
  // Saturating count of deselected cycles; long enough to cover the synchroniser delay.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) csIdle_reg <= 4'h0;
    else if (!chipSel_n) csIdle_reg <= 4'h0;
    else if (csIdle_reg != 4'hF) csIdle_reg <= csIdle_reg + 4'h1;
  end
  strobe_pulse_a: assert property (regWrite || regRead |=> !regWrite && !regRead)
    else $error("strobe longer than one cycle");
  cs_quiet_a: assert property (csIdle_reg == 4'hF && !ifaceSelI2c |-> !regWrite && !regRead)
    else $error("strobe while deselected");
  fifo_reset_a: assert property (disable iff (1'b0) !rstn |-> !fifoEnable)
    else $error("fifo enable set in reset");
  fifo_cause_a: assert property ($changed(fifoEnable) |-> fifoWr || $past(fifoWr) || $past(fifoWr, 2))
    else $error("fifo enable changed without a write");
  fifo_value_a: assert property (fifoWr |-> ##[0:2] fifoEnable == regWdata[FIFO_EN_BIT])
    else $error("fifo enable not taken from written bit");
  tx_fifo_a: assert property ((fifoEnable && !rs485Auto && txLevel < txTrigger)[*3] |-> !irq_n)
    else $error("no interrupt below transmit trigger");
  tx_hold_a: assert property ((!fifoEnable && !rs485Auto && txHoldEmpty)[*3] |-> !irq_n)
    else $error("no interrupt on empty holding register");
  rs485_empty_a: assert property ((!fifoEnable && rs485Auto && txAllEmpty)[*3] |-> !irq_n)
    else $error("no interrupt on empty transmitter");
  rs485_busy_a: assert property ((!fifoEnable && rs485Auto && !txAllEmpty && !rxDataReady)[*3] |-> irq_n)
    else $error("interrupt while transmitter busy");
  rx_fifo_a: assert property ((fifoEnable && rxLevel > rxTrigger)[*3] |-> !irq_n)
    else $error("no interrupt above receive trigger");
  spi_sda_a: assert property ((!ifaceSelI2c)[*4] |-> sdaOe_n)
    else $error("data pin driven in serial peripheral mode");
  cover property (regWrite);
  cover property (regRead);
  cover property (fifoEnable && !irq_n);
endmodule // serial_host_port_chk
bind serial_host_register_port serial_host_port_chk u_chk (.clk_sys, .rstn, .ifaceSelI2c, .chipSel_n,
  .sdaOe_n, .regWrite, .regRead, .regAddr, .regWdata, .rs485Auto, .txHoldEmpty, .txAllEmpty, .txLevel,
  .txTrigger, .rxLevel, .rxTrigger, .rxDataReady, .irq_n, .fifoEnable);

//--- bench/tb_serial_host_register_port.sv
// Self-checking bench: SPI register accesses and interrupt pin levels.
`timescale 1ns/10ps
module tb_serial_host_register_port;
  import serial_host_port_pkg::*;
  logic               clk_sys, rstn, sclIn, chipSel_n, slaveIn, slaveOut, sdaOe_n, irq_n, fifoEnable;
  logic               regWrite, regRead, rs485Auto, txHoldEmpty, txAllEmpty, rxDataReady;
  logic [0:0]         regChan, wC, rC;
  logic [3:0]         regAddr, wA, rA;
  logic [7:0]         regWdata, regRdata, wD, rxByte;
  logic [1:0]         txFull;
  logic [LEVEL_W-1:0] txLevel, txTrigger, rxLevel, rxTrigger;
  logic               spiSck, i2cMode, sclI, sdaM, sdaLine, sdaOut, ack;
  int                 mismatches, n_tests, cycles, wN, rN, n0, r0;
  // Straps ground and clock select address 0x6C, that is 7'h36 ahead of the direction bit.
  serial_host_register_port DUT (.clk_sys, .rstn, .ifaceSelI2c(i2cMode), .addr_strap_hi(2'h1),
    .addr_strap_lo(2'h2), .sclIn, .sdaIn(sdaLine), .sdaOut, .sdaOe_n, .chipSel_n, .slaveIn, .slaveOut,
    .regWrite, .regRead, .regChan, .regAddr, .regWdata, .regRdata, .txFull, .rs485Auto, .txHoldEmpty,
    .txAllEmpty, .txLevel, .txTrigger, .rxLevel, .rxTrigger, .rxDataReady, .irq_n, .fifoEnable);
  spi_host_model host (.sck(spiSck), .csN(chipSel_n), .mosi(slaveIn), .miso(slaveOut));
  // Both ends of the open-drain data line can only pull it low.
  assign sclIn   = i2cMode ? sclI : spiSck;
  assign sdaLine = sdaM & (sdaOe_n | sdaOut);
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (regWrite === 1'b1) begin
      wN++;
      wA = regAddr;
      wC = regChan;
      wD = regWdata;
    end
    if (regRead === 1'b1) begin
      rN++;
      rA = regAddr;
      rC = regChan;
    end
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick();
    @(posedge clk_sys);
    #2;
  endtask
  // One selected frame: control byte, then nb data bytes counting up from d.
  task automatic spi(input logic rd, input logic [3:0] ra, input logic [1:0] ch, input int nb, input logic [7:0] d);
    tick();
    n0 = wN;
    host.start();
    host.xfer({rd, ra, ch, 1'b0}, rxByte);
    for (int i = 0; i < nb; i++) host.xfer(d + 8'(i), rxByte);
    host.stop();
    repeat (10) tick();
  endtask
  task automatic irq_case(input logic r, h, a, input logic [6:0] tl, tt, rl, rt, input logic e);
    tick();
    {rs485Auto, txHoldEmpty, txAllEmpty} = {r, h, a};
    {txLevel, txTrigger, rxLevel, rxTrigger} = {tl, tt, rl, rt};
    repeat (3) tick();
    chk("irq_n", irq_n, {7'h00, e});
  endtask
  task automatic i2c_bit(input logic b, output logic r);
    sdaM = b;
    #200;
    sclI = 1'b1;
    #100;
    r = sdaLine;
    #100;
    sclI = 1'b0;
  endtask
  // Eight bits, then the acknowledge slot with the host releasing the line.
  task automatic i2c_byte(input logic [7:0] b, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) i2c_bit(b[i], r[i]);
    i2c_bit(1'b1, a);
  endtask
  task automatic i2c(input logic rd, input logic [7:0] sub, input logic [7:0] d, output logic [7:0] r,
                     output logic a);
    tick();
    sdaM = 1'b0;
    #200;
    sclI = 1'b0;
    i2c_byte({7'h36, rd}, r, a);
    chk("addrAck", a, 8'h00);
    if (!rd) i2c_byte(sub, r, a);
    i2c_byte(rd ? 8'hFF : d, r, a);
    sdaM = 1'b0;
    #200;
    sclI = 1'b1;
    #200;
    sdaM = 1'b1;
    #400;
  endtask
  initial begin
    rstn = 1'b0;
    {regRdata, txFull, rxDataReady} = 11'h000;
    {i2cMode, sclI, sdaM} = 3'h3;
    irq_case(1'b0, 1'b0, 1'b0, 7'h00, 7'h00, 7'h00, 7'h00, 1'b1);
    chk("fifoEnable", fifoEnable, 8'h00);
    chk("sdaOe_n", sdaOe_n, 8'h01);
    rstn = 1'b1;
    repeat (6) tick();
    irq_case(1'b0, 1'b0, 1'b0, 7'h00, 7'h00, 7'h00, 7'h00, 1'b1);
    irq_case(1'b0, 1'b1, 1'b1, 7'h00, 7'h00, 7'h00, 7'h00, 1'b0);
    irq_case(1'b1, 1'b1, 1'b0, 7'h00, 7'h00, 7'h00, 7'h00, 1'b1);
    irq_case(1'b1, 1'b1, 1'b1, 7'h00, 7'h00, 7'h00, 7'h00, 1'b0);
    $display("test non-fifo interrupt done");
    spi(1'b0, REG_FIFO_CTRL, CH_FIRST, 1, 8'h01);
    chk("wA", wA, REG_FIFO_CTRL);
    chk("wC", wC, 8'h00);
    chk("wD", wD, 8'h01);
    chk("fifoEnable", fifoEnable, 8'h01);
    spi(1'b0, REG_HOLDING, CH_SECOND, 1, 8'hA5);
    chk("wC", wC, 8'h01);
    chk("wD", wD, 8'hA5);
    for (int c = 2; c < 4; c++) begin
      spi(1'b0, REG_FIFO_CTRL, 2'(c), 1, 8'h00);
      chk("wN", 8'(wN - n0), 8'h00);
      chk("fifoEnable", fifoEnable, 8'h01);
    end
    $display("test writes done");
    irq_case(1'b0, 1'b0, 1'b0, 7'h14, 7'h08, 7'h02, 7'h08, 1'b1);
    irq_case(1'b0, 1'b0, 1'b0, 7'h04, 7'h08, 7'h02, 7'h08, 1'b0);
    irq_case(1'b0, 1'b0, 1'b0, 7'h14, 7'h08, 7'h10, 7'h08, 1'b0);
    irq_case(1'b1, 1'b0, 1'b0, 7'h14, 7'h08, 7'h02, 7'h08, 1'b1);
    $display("test fifo interrupt done");
    regRdata = 8'hC3;
    r0 = rN;
    spi(1'b1, 4'h5, CH_SECOND, 1, 8'h00);
    // The byte after the one sent is fetched ahead while the frame is still open.
    chk("rN", 8'(rN - r0), 8'h02);
    chk("rA", rA, 8'h05);
    chk("rC", rC, 8'h01);
    chk("slaveOut", rxByte, 8'hC3);
    spi(1'b0, REG_HOLDING, CH_FIRST, FIFO_DEPTH + 1, 8'h00);
    chk("wN", 8'(wN - n0), 8'(FIFO_DEPTH));
    chk("wD", wD, 8'(FIFO_DEPTH - 1));
    $display("test burst done");
    i2cMode = 1'b1;
    txFull = 2'h2;
    repeat (6) tick();
    i2c(1'b0, {1'b0, REG_HOLDING, CH_FIRST, 1'b0}, 8'h3C, rxByte, ack);
    chk("ack", ack, 8'h00);
    chk("wA", wA, REG_HOLDING);
    chk("wC", wC, 8'h00);
    chk("wD", wD, 8'h3C);
    i2c(1'b0, {1'b0, REG_HOLDING, CH_SECOND, 1'b0}, 8'h96, rxByte, ack);
    chk("ack", ack, 8'h01);
    regRdata = 8'h5A;
    r0 = rN;
    i2c(1'b1, 8'h00, 8'h00, rxByte, ack);
    chk("sdaRead", rxByte, 8'h5A);
    chk("rN", 8'(rN - r0), 8'h01);
    chk("rC", rC, 8'h01);
    i2cMode = 1'b0;
    repeat (6) tick();
    $display("test i2c done");
    rstn = 1'b0;
    repeat (3) tick();
    chk("fifoEnable", fifoEnable, 8'h00);
    chk("sdaOut", sdaOut, 8'h01);
    chk("slaveOut", slaveOut, 8'h00);
    rstn = 1'b1;
    repeat (6) tick();
    chk("fifoEnable", fifoEnable, 8'h00);
    $display("test mid reset done");
    close_out();
  end
endmodule // tb_serial_host_register_port
